// ===== hdl/pd_policy_pkg.sv
package pd_policy_pkg;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PDO_COUNT_OFS = 8'h08;
    localparam logic [7:0] PDO0_OFS = 8'h0C;
    localparam logic [7:0] PDO1_OFS = 8'h10;
    localparam logic [7:0] PDO2_OFS = 8'h14;

    // control fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_RESTART_BIT = 1;
    localparam logic CTRL_ENABLE_RST = 1'h0;

    // status fields
    localparam int ST_VALID_BIT = 0;
    localparam int ST_RCPT_LSB = 1;
    localparam int ST_PROVIDER_BIT = 3;
    localparam int ST_RUNNING_BIT = 4;
    localparam int ST_EXT_BIT = 5;
    localparam int ST_MICRO_A_BIT = 6;
    localparam int ST_PENDING_BIT = 7;
    localparam int ST_CFG_LSB = 8;

    // power data object fields (fixed supply layout)
    localparam int PDO_CUR_LSB = 0;
    localparam int PDO_VOLT_LSB = 10;
    localparam int PDO_PEAK_LSB = 20;
    localparam logic [1:0] PEAK_DOUBLE = 2'h3;
    localparam logic [1:0] PEAK_NONE = 2'h0;

    // voltages in 50 mV units, currents in 10 mA units
    localparam logic [9:0] VOLT_5V = 10'h064;
    localparam logic [9:0] VOLT_12V = 10'h0F0;
    localparam logic [9:0] VOLT_20V = 10'h190;
    localparam logic [9:0] CUR_0A = 10'h000;
    localparam logic [9:0] CUR_1A = 10'h064;
    localparam logic [9:0] CUR_1A5 = 10'h096;
    localparam logic [9:0] CUR_2A = 10'h0C8;
    localparam logic [9:0] CUR_3A = 10'h12C;
    localparam logic [9:0] CUR_5A = 10'h1F4;

    // provider option bits of a configuration
    localparam int OPT_LEGACY = 0;
    localparam int OPT_P1 = 1;
    localparam int OPT_P2 = 2;
    localparam int OPT_P3 = 3;
    localparam int OPT_P4 = 4;
    localparam int OPT_P5 = 5;
    localparam int OPT_12V1A5 = 6;
    localparam int OPT_12V3A = 7;
    localparam int OPT_12V5A = 8;
    localparam int OPT_20V3A = 9;
    localparam int OPT_20V5A = 10;
    localparam int OPT_PEAK = 11;
    localparam int OPT_W = 12;

    typedef enum logic [1:0] {
        CLS_DFP_A = 2'b00,
        CLS_UFP_B = 2'b01,
        CLS_PC_A = 2'b10,
        CLS_PC_MICRO = 2'b11
    } cfg_class_t;

    typedef enum logic [1:0] {
        RCPT_NONE = 2'b00,
        RCPT_STANDARD_A_RECEPTACLE = 2'b01,
        RCPT_STANDARD_B_RECEPTACLE = 2'b10,
        RCPT_MICRO = 2'b11
    } rcpt_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_START = 2'b01,
        ST_RUN = 2'b10,
        ST_WAIT = 2'b11
    } fsm_t;

    typedef struct packed {
        logic valid;
        cfg_class_t cls;
        logic [4:0] num;
        logic [OPT_W-1:0] opts;
    } cfg_t;

    // pins sampled through the synchroniser
    typedef struct packed {
        logic [3:0] strap_select_high;
        logic [3:0] strap_select_low;
        logic ext_power;
        logic micro_a_present;
    } pins_t;

    // swap exchange and hard reset with the protocol engine
    typedef struct packed {
        logic swap_in_valid;
        logic swap_out_done;
        logic swap_out_accepted;
        logic hard_reset;
    } link_in_t;

    typedef struct packed {
        logic swap_out_req;
        logic swap_accept;
        logic swap_reject;
    } link_out_t;

endpackage : pd_policy_pkg

// ===== hdl/pd_role_policy.sv
// Design decisions made here: the placing of the registers and register access over APB.
`timescale 1ns/100ps
module pd_role_policy (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // strap and detection pins
    input wire pd_policy_pkg::pins_t pins,
    // protocol engine
    input wire pd_policy_pkg::link_in_t link_in,
    output pd_policy_pkg::link_out_t link_out,
    // policy state
    output logic provider_role,
    output logic role_active,
    output pd_policy_pkg::rcpt_t receptacle,
    output logic config_valid
);
    import pd_policy_pkg::*;

    typedef struct packed {
        pins_t sync1;
        pins_t sync2;
        fsm_t fsm;
        cfg_t cfg;
        logic enable;
        logic restart;
        logic provider;
        logic tried;
        logic ext_last;
        link_out_t lo;
        logic [2:0][31:0] pdo;
        logic [1:0] pdo_count;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic active;
        rcpt_t rcpt;
    } state_t;

    state_t s_q;
    state_t s_d;

    function automatic cfg_t decode(input logic [3:0] hi,
                                    input logic [3:0] lo);
        cfg_t c;
        c = '0;
        c.valid = 1'b1;
        unique case (hi)
            4'h3: begin
                c.cls = CLS_DFP_A;
                c.num = 5'(lo);
                unique case (lo)
                    4'h1: c.opts[OPT_P1] = 1'b1;
                    4'h2: c.opts[OPT_P2] = 1'b1;
                    4'h3: c.opts[OPT_P3] = 1'b1;
                    4'h4: c.opts[OPT_P4] = 1'b1;
                    4'h5: c.opts[OPT_P5] = 1'b1;
                    4'h6: c.opts[OPT_12V1A5] = 1'b1;
                    4'h7: c.opts[OPT_12V3A] = 1'b1;
                    4'h8: c.opts[OPT_12V5A] = 1'b1;
                    default: c.valid = 1'b0;
                endcase
            end
            4'h4: begin
                c.cls = CLS_UFP_B;
                c.num = 5'(lo) + 5'h08;
                unique case (lo)
                    4'h1: c.opts[OPT_20V3A] = 1'b1;
                    4'h2: c.opts[OPT_20V5A] = 1'b1;
                    4'h3: c.opts[OPT_P4] = 1'b1;
                    4'h4: c.opts[OPT_P4] = 1'b1;
                    4'h5: c.opts[OPT_P5] = 1'b1;
                    4'h6: c.opts[OPT_P5] = 1'b1;
                    default: c.valid = 1'b0;
                endcase
                c.opts[OPT_PEAK] = (lo == 4'h4) || (lo == 4'h6);
            end
            4'h1: begin
                c.cls = CLS_PC_A;
                c.num = 5'(lo) + 5'h0E;
                c.valid = (lo >= 4'h1) && (lo <= 4'h8);
                c.opts[OPT_LEGACY] = (lo <= 4'h2);
                c.opts[OPT_P1] = (lo > 4'h2);
                c.opts[OPT_PEAK] = (lo > 4'h2) && !lo[0];
            end
            4'h2: begin
                c.cls = (lo <= 4'h2) ? CLS_PC_A : CLS_PC_MICRO;
                c.num = 5'(lo) + 5'h16;
                c.valid = (lo >= 4'h1) && (lo <= 4'h8);
                c.opts[OPT_LEGACY] = (lo == 4'h3) || (lo == 4'h4);
                c.opts[OPT_P1] = (lo <= 4'h2) || (lo >= 4'h5);
                c.opts[OPT_PEAK] = (lo == 4'h2) || ((lo >= 4'h5) && !lo[0]);
            end
            default: c.valid = 1'b0;
        endcase
        if (!c.valid) begin
            c = '0;
        end
        return c;
    endfunction : decode

    function automatic logic [9:0] max_cur(input logic [9:0] a,
                                           input logic [9:0] b);
        return (a > b) ? a : b;
    endfunction : max_cur

    // decode of the synchronised straps
    cfg_t cfg_now;
    // merged supply currents per voltage
    logic [9:0] cur5;
    logic [9:0] cur12;
    logic [9:0] cur20;
    logic [1:0] peak;
    logic [2:0][31:0] pdo_now;
    logic [1:0] pdo_cnt_now;
    // swap policy
    logic is_micro_a;
    logic dual_role;
    logic may_accept;
    logic may_initiate;
    logic default_provider;
    // apb
    logic setup;
    logic access;

    always_comb begin
        logic [31:0] obj;
        obj = '0;
        cfg_now = decode(s_q.sync2.strap_select_high,
                         s_q.sync2.strap_select_low);
        cur5 = CUR_0A;
        cur12 = CUR_0A;
        cur20 = CUR_0A;
        if (cfg_now.opts[OPT_LEGACY]) begin
            cur5 = CUR_1A;
        end
        if (|cfg_now.opts[OPT_P5:OPT_P1]) begin
            cur5 = max_cur(cur5, CUR_2A);
        end
        if (cfg_now.opts[OPT_P2] || cfg_now.opts[OPT_12V1A5]) begin
            cur12 = max_cur(cur12, CUR_1A5);
        end
        if (cfg_now.opts[OPT_P3] || cfg_now.opts[OPT_P4]
                || cfg_now.opts[OPT_12V3A]) begin
            cur12 = max_cur(cur12, CUR_3A);
        end
        if (cfg_now.opts[OPT_P5] || cfg_now.opts[OPT_12V5A]) begin
            cur12 = max_cur(cur12, CUR_5A);
        end
        if (cfg_now.opts[OPT_P4] || cfg_now.opts[OPT_20V3A]) begin
            cur20 = max_cur(cur20, CUR_3A);
        end
        if (cfg_now.opts[OPT_P5] || cfg_now.opts[OPT_20V5A]) begin
            cur20 = max_cur(cur20, CUR_5A);
        end
        // a 5 V object is offered with every valid configuration
        if (cfg_now.valid && cur5 == CUR_0A) begin
            cur5 = CUR_1A;
        end
        peak = cfg_now.opts[OPT_PEAK] ? PEAK_DOUBLE : PEAK_NONE;
        // one object per voltage, packed from the lowest voltage up
        pdo_now = '0;
        pdo_cnt_now = 2'h0;
        if (cfg_now.valid) begin
            obj = '0;
            obj[PDO_PEAK_LSB +: 2] = peak;
            obj[PDO_VOLT_LSB +: 10] = VOLT_5V;
            obj[PDO_CUR_LSB +: 10] = cur5;
            pdo_now[0] = obj;
            pdo_cnt_now = 2'h1;
            if (cur12 != CUR_0A) begin
                obj[PDO_VOLT_LSB +: 10] = VOLT_12V;
                obj[PDO_CUR_LSB +: 10] = cur12;
                pdo_now[pdo_cnt_now] = obj;
                pdo_cnt_now = pdo_cnt_now + 2'h1;
            end
            if (cur20 != CUR_0A) begin
                obj[PDO_VOLT_LSB +: 10] = VOLT_20V;
                obj[PDO_CUR_LSB +: 10] = cur20;
                pdo_now[pdo_cnt_now] = obj;
                pdo_cnt_now = pdo_cnt_now + 2'h1;
            end
        end
    end

    always_comb begin
        is_micro_a = s_q.sync2.micro_a_present;
        dual_role = (s_q.cfg.cls == CLS_PC_A)
            || (s_q.cfg.cls == CLS_PC_MICRO && is_micro_a);
        may_accept = 1'b0;
        may_initiate = 1'b0;
        default_provider = 1'b0;
        if (s_q.cfg.valid) begin
            unique case (s_q.cfg.cls)
                CLS_DFP_A: begin
                    default_provider = 1'b1;
                end
                CLS_UFP_B: begin
                    may_accept = 1'b1;
                    may_initiate = !s_q.provider;
                end
                CLS_PC_A, CLS_PC_MICRO: begin
                    default_provider = dual_role;
                    if (dual_role) begin
                        // current level of the external supply
                        may_accept = s_q.provider ? !s_q.sync2.ext_power
                                                  : s_q.sync2.ext_power;
                        may_initiate = may_accept;
                    end
                end
            endcase
        end
    end

    always_comb begin
        setup = psel && !penable;
        access = psel && penable;
        s_d = s_q;
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.cfg = cfg_now;
        s_d.pdo = pdo_now;
        s_d.pdo_count = pdo_cnt_now;
        s_d.ext_last = s_q.sync2.ext_power;
        s_d.lo.swap_accept = 1'b0;
        s_d.lo.swap_reject = 1'b0;
        s_d.restart = 1'b0;
        // apb: answer in the first access cycle
        s_d.pready = setup;
        s_d.pslverr = 1'b0;
        s_d.prdata = '0;
        if (setup) begin
            unique case (paddr)
                CTRL_OFS: begin
                    s_d.prdata[CTRL_ENABLE_BIT] = s_q.enable;
                end
                STATUS_OFS: begin
                    s_d.prdata[ST_VALID_BIT] = s_q.cfg.valid;
                    s_d.prdata[ST_RCPT_LSB +: 2] = receptacle;
                    s_d.prdata[ST_PROVIDER_BIT] = s_q.provider;
                    s_d.prdata[ST_RUNNING_BIT] = role_active;
                    s_d.prdata[ST_EXT_BIT] = s_q.sync2.ext_power;
                    s_d.prdata[ST_MICRO_A_BIT] = is_micro_a;
                    s_d.prdata[ST_PENDING_BIT] = s_q.lo.swap_out_req;
                    s_d.prdata[ST_CFG_LSB +: 5] = s_q.cfg.num;
                end
                PDO_COUNT_OFS: s_d.prdata[1:0] = s_q.pdo_count;
                PDO0_OFS: s_d.prdata = s_q.pdo[0];
                PDO1_OFS: s_d.prdata = s_q.pdo[1];
                PDO2_OFS: s_d.prdata = s_q.pdo[2];
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (access && pready && pwrite && paddr == CTRL_OFS) begin
            s_d.enable = pwdata[CTRL_ENABLE_BIT];
            s_d.restart = pwdata[CTRL_RESTART_BIT];
        end
        // role machine
        unique case (s_q.fsm)
            ST_IDLE: begin
                s_d.provider = 1'b0;
                s_d.lo.swap_out_req = 1'b0;
                if (s_q.enable) begin
                    s_d.fsm = ST_START;
                end
            end
            ST_START: begin
                s_d.provider = default_provider;
                s_d.tried = 1'b0;
                s_d.lo.swap_out_req = 1'b0;
                s_d.fsm = ST_RUN;
            end
            ST_RUN: begin
                if (link_in.swap_in_valid) begin
                    if (may_accept) begin
                        s_d.lo.swap_accept = 1'b1;
                        s_d.provider = !s_q.provider;
                        s_d.tried = s_q.cfg.cls == CLS_UFP_B;
                    end else begin
                        s_d.lo.swap_reject = 1'b1;
                    end
                end else if (may_initiate && !s_q.tried) begin
                    s_d.lo.swap_out_req = 1'b1;
                    s_d.tried = 1'b1;
                    s_d.fsm = ST_WAIT;
                end
                if (s_q.cfg.cls != CLS_UFP_B
                        && s_q.ext_last != s_q.sync2.ext_power) begin
                    s_d.tried = 1'b0;
                end
                if (s_q.cfg.cls == CLS_PC_MICRO && !is_micro_a) begin
                    s_d.provider = 1'b0;
                end
            end
            ST_WAIT: begin
                if (link_in.swap_in_valid) begin
                    s_d.lo.swap_reject = 1'b1;
                end
                if (link_in.swap_out_done) begin
                    s_d.lo.swap_out_req = 1'b0;
                    s_d.fsm = ST_RUN;
                    if (link_in.swap_out_accepted) begin
                        s_d.provider = !s_q.provider;
                        s_d.tried = s_q.cfg.cls == CLS_UFP_B;
                    end
                end
            end
        endcase
        // restart from startup on hard reset, software restart or new straps
        if (s_q.fsm != ST_IDLE && (link_in.hard_reset || s_q.restart
                || cfg_now != s_q.cfg)) begin
            s_d.fsm = ST_START;
            s_d.lo.swap_out_req = 1'b0;
        end
        if (!s_q.enable) begin
            s_d.fsm = ST_IDLE;
            s_d.lo.swap_out_req = 1'b0;
        end
        // role outputs leave the block from flops
        s_d.active = (s_d.fsm == ST_RUN || s_d.fsm == ST_WAIT)
            && s_d.cfg.valid;
        unique case (s_d.cfg.cls)
            CLS_DFP_A, CLS_PC_A: s_d.rcpt = RCPT_STANDARD_A_RECEPTACLE;
            CLS_UFP_B: s_d.rcpt = RCPT_STANDARD_B_RECEPTACLE;
            CLS_PC_MICRO: s_d.rcpt = RCPT_MICRO;
        endcase
        if (!s_d.cfg.valid) begin
            s_d.rcpt = RCPT_NONE;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.enable <= CTRL_ENABLE_RST;
        end else begin
            s_q <= s_d;
        end
    end

    always_comb begin
        prdata = s_q.prdata;
        pready = s_q.pready;
        pslverr = s_q.pslverr;
        link_out = s_q.lo;
        provider_role = s_q.provider;
        role_active = s_q.active;
        config_valid = s_q.cfg.valid;
        receptacle = s_q.rcpt;
    end

endmodule : pd_role_policy

// ===== bench/pd_role_policy_asserts.sv
`timescale 1ns/100ps
module pd_role_policy_checker (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb answer
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // pins and link
    input wire pd_policy_pkg::pins_t pins,
    input wire pd_policy_pkg::link_in_t link_in,
    input wire pd_policy_pkg::link_out_t link_out,
    // policy state
    input wire logic provider_role,
    input wire logic role_active,
    input wire pd_policy_pkg::rcpt_t receptacle,
    input wire logic config_valid
);
    import pd_policy_pkg::*;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_unmapped;
        pready && paddr > PDO2_OFS |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_valid_rcpt;
        config_valid == (receptacle != RCPT_NONE);
    endproperty
    a_valid_rcpt: assert property (p_valid_rcpt)
        else $error("receptacle and valid disagree");
    property p_dfp_quiet;
        (pins.strap_select_high == 4'h3)[*6] ##0 role_active
            |-> !link_out.swap_out_req && !link_out.swap_accept;
    endproperty
    a_dfp_quiet: assert property (p_dfp_quiet)
        else $error("provider-only port swapped");
    property p_ufp_start;
        $rose(role_active) && receptacle == RCPT_STANDARD_B_RECEPTACLE |-> !provider_role;
    endproperty
    a_ufp_start: assert property (p_ufp_start)
        else $error("upstream port did not start consumer");
    property p_ufp_accept;
        role_active && receptacle == RCPT_STANDARD_B_RECEPTACLE && !provider_role
            && !link_out.swap_out_req && link_in.swap_in_valid
            |=> link_out.swap_accept;
    endproperty
    a_ufp_accept: assert property (p_ufp_accept)
        else $error("upstream consumer did not accept");
    property p_ufp_no_give;
        receptacle == RCPT_STANDARD_B_RECEPTACLE && provider_role |-> !link_out.swap_out_req;
    endproperty
    a_ufp_no_give: assert property (p_ufp_no_give)
        else $error("upstream provider requested swap");
    property p_flip;
        link_out.swap_accept |-> provider_role != $past(provider_role);
    endproperty
    a_flip: assert property (p_flip)
        else $error("accept without role change");
    property p_cause;
        link_out.swap_accept || link_out.swap_reject
            |-> $past(link_in.swap_in_valid);
    endproperty
    a_cause: assert property (p_cause)
        else $error("answer without request");
    property p_prov_ext;
        pins.ext_power[*4] ##0 (role_active && provider_role
            && receptacle != RCPT_STANDARD_B_RECEPTACLE && link_in.swap_in_valid)
            |=> !link_out.swap_accept;
    endproperty
    a_prov_ext: assert property (p_prov_ext)
        else $error("powered provider accepted");
    property p_cons_noext;
        (!pins.ext_power)[*4] ##0 (role_active && !provider_role
            && receptacle != RCPT_STANDARD_B_RECEPTACLE && link_in.swap_in_valid)
            |=> !link_out.swap_accept;
    endproperty
    a_cons_noext: assert property (p_cons_noext)
        else $error("unpowered consumer accepted");
    property p_micro_cons;
        (!pins.micro_a_present)[*6] ##0
            (role_active && receptacle == RCPT_MICRO)
            |-> !provider_role && !link_out.swap_out_req;
    endproperty
    a_micro_cons: assert property (p_micro_cons)
        else $error("micro port without plug not consumer");
    property p_req_hold;
        link_out.swap_out_req && !link_in.swap_out_done
            && !link_in.hard_reset |=> link_out.swap_out_req || !role_active;
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("own request dropped early");
endmodule : pd_role_policy_checker

bind pd_role_policy pd_role_policy_checker u_chk (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .link_in(link_in),
    .link_out(link_out), .provider_role(provider_role),
    .role_active(role_active), .receptacle(receptacle),
    .config_valid(config_valid)
);

// ===== bench/pd_partner_model.sv
`timescale 1ns/100ps
module pd_partner_model (
    // clock
    input wire logic pclk,
    // link
    input wire pd_policy_pkg::link_out_t link_out,
    output pd_policy_pkg::link_in_t link_in
);
    import pd_policy_pkg::*;
    logic ask = 1'b0;
    logic done = 1'b0;
    logic hr = 1'b0;
    logic grant = 1'b0;
    int answer_delay = 1;
    int wait_n = 0;
    int asked = 0;
    // answer line is only meaningful with done
    assign link_in = '{ask, done, done ? grant : ~grant, hr};
    // answers an own request answer_delay + 1 cycles after it is raised
    always @(posedge pclk) begin
        done <= 1'b0;
        if (done) begin
            asked <= asked + 1;
        end
        if (link_out.swap_out_req && !done) begin
            wait_n <= wait_n + 1;
            if (wait_n >= answer_delay) begin
                done <= 1'b1;
                wait_n <= 0;
            end
        end else begin
            wait_n <= 0;
        end
    end
    // ans: 2'b10 accepted, 2'b01 rejected, 2'b00 silent
    task automatic request(output logic [1:0] ans);
        ans = 2'b00;
        @(posedge pclk);
        ask <= 1'b1;
        @(posedge pclk);
        ask <= 1'b0;
        for (int n = 0; n < 4 && ans == 2'b00; n++) begin
            @(posedge pclk);
            ans = {link_out.swap_accept, link_out.swap_reject};
        end
    endtask : request
    task automatic hard_rst;
        @(posedge pclk);
        hr <= 1'b1;
        @(posedge pclk);
        hr <= 1'b0;
    endtask : hard_rst
endmodule : pd_partner_model

// ===== bench/tb.sv
`timescale 1ns/100ps
module tb;
    import pd_policy_pkg::*;
    localparam logic [31:0] PK = {10'h0, PEAK_DOUBLE, 20'h0};
    localparam logic [31:0] V5A1 = {12'h0, VOLT_5V, CUR_1A};
    localparam logic [31:0] V5A2 = {12'h0, VOLT_5V, CUR_2A};
    localparam logic [31:0] V12A15 = {12'h0, VOLT_12V, CUR_1A5};
    localparam logic [31:0] V12A3 = {12'h0, VOLT_12V, CUR_3A};
    localparam logic [31:0] V12A5 = {12'h0, VOLT_12V, CUR_5A};
    localparam logic [31:0] V20A3 = {12'h0, VOLT_20V, CUR_3A};
    localparam logic [31:0] V20A5 = {12'h0, VOLT_20V, CUR_5A};
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic provider_role, role_active, config_valid;
    pins_t pins;
    link_in_t link_in;
    link_out_t link_out;
    rcpt_t receptacle;
    int err_count = 0;
    int total_checks = 0;

    pd_role_policy u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .pins(pins),
        .link_in(link_in), .link_out(link_out),
        .provider_role(provider_role), .role_active(role_active),
        .receptacle(receptacle), .config_valid(config_valid)
    );
    pd_partner_model u_partner (
        .pclk(pclk), .link_out(link_out), .link_in(link_in)
    );

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [32:0] g, input logic [32:0] e);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [32:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        logic [32:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask : rd
    task automatic setup(input logic [3:0] hi, lo, input logic ext, mic);
        logic [32:0] r;
        @(posedge pclk);
        pins <= '{hi, lo, ext, mic};
        u_partner.asked = 0;
        repeat (4) @(posedge pclk);
        apb(1'b1, CTRL_OFS, 32'h3, r);
        repeat (6) @(posedge pclk);
    endtask : setup
    task automatic sw(input logic [1:0] e, input logic prov);
        logic [1:0] ans;
        u_partner.request(ans);
        chk({ans, provider_role}, {e, prov});
    endtask : sw
    task automatic pdo_row(input logic [3:0] hi, lo, input logic [4:0] num,
        input rcpt_t rc, input logic [1:0] cnt, input logic [31:0] p0, p1, p2);
        logic [32:0] r;
        setup(hi, lo, 1'b0, 1'b0);
        apb(1'b0, STATUS_OFS, 32'h0, r);
        chk(r & 33'h1F07, {20'h0, num, 5'h0, rc, 1'b1});
        rd(PDO_COUNT_OFS, {31'h0, cnt});
        rd(PDO0_OFS, {1'b0, p0});
        rd(PDO1_OFS, {1'b0, p1});
        rd(PDO2_OFS, {1'b0, p2});
    endtask : pdo_row

    task automatic t_regs;
        logic [32:0] r;
        rd(CTRL_OFS, 33'h0);
        apb(1'b1, 8'h18, 32'hFFFF_FFFF, r);
        chk(r, 33'h1_0000_0000);
        rd(8'h18, 33'h1_0000_0000);
        setup(4'h5, 4'h1, 1'b0, 1'b0);
        rd(STATUS_OFS, 33'h0);
        sw(2'b01, 1'b0);
        $display("registers done");
    endtask : t_regs
    task automatic t_pdo;
        pdo_row(4'h3, 4'h1, 5'd1, RCPT_STANDARD_A_RECEPTACLE, 2'd1, V5A2, 0, 0);
        pdo_row(4'h3, 4'h2, 5'd2, RCPT_STANDARD_A_RECEPTACLE, 2'd2, V5A2, V12A15, 0);
        pdo_row(4'h3, 4'h3, 5'd3, RCPT_STANDARD_A_RECEPTACLE, 2'd2, V5A2, V12A3, 0);
        pdo_row(4'h3, 4'h4, 5'd4, RCPT_STANDARD_A_RECEPTACLE, 2'd3, V5A2, V12A3, V20A3);
        pdo_row(4'h3, 4'h5, 5'd5, RCPT_STANDARD_A_RECEPTACLE, 2'd3, V5A2, V12A5, V20A5);
        pdo_row(4'h3, 4'h7, 5'd7, RCPT_STANDARD_A_RECEPTACLE, 2'd2, V5A1, V12A3, 0);
        pdo_row(4'h4, 4'h6, 5'd14, RCPT_STANDARD_B_RECEPTACLE, 2'd3, V5A2 | PK, V12A5 | PK,
            V20A5 | PK);
        pdo_row(4'h1, 4'h1, 5'd15, RCPT_STANDARD_A_RECEPTACLE, 2'd1, V5A1, 0, 0);
        pdo_row(4'h2, 4'h6, 5'd28, RCPT_MICRO, 2'd1, V5A2 | PK, 0, 0);
        $display("capabilities done");
    endtask : t_pdo
    task automatic t_dfp;
        setup(4'h3, 4'h1, 1'b0, 1'b0);
        sw(2'b01, 1'b1);
        chk(u_partner.asked, 0);
        $display("provider only done");
    endtask : t_dfp
    task automatic t_ufp;
        u_partner.grant = 1'b0;
        u_partner.answer_delay = 20;
        setup(4'h4, 4'h3, 1'b0, 1'b0);
        chk({link_out.swap_out_req, provider_role}, 2'b10);
        repeat (25) @(posedge pclk);
        chk({u_partner.asked, provider_role}, 2'b10);
        sw(2'b10, 1'b1);
        repeat (8) @(posedge pclk);
        sw(2'b10, 1'b0);
        repeat (8) @(posedge pclk);
        chk(u_partner.asked, 1);
        u_partner.grant = 1'b1;
        u_partner.hard_rst();
        repeat (40) @(posedge pclk);
        chk({u_partner.asked, provider_role}, 3'b101);
        u_partner.answer_delay = 1;
        $display("upstream done");
    endtask : t_ufp
    task automatic t_dual;
        setup(4'h1, 4'h1, 1'b1, 1'b0);
        sw(2'b01, 1'b1);
        pins.ext_power <= 1'b0;
        repeat (10) @(posedge pclk);
        chk({u_partner.asked, provider_role}, 2'b10);
        sw(2'b01, 1'b0);
        u_partner.grant = 1'b0;
        pins.ext_power <= 1'b1;
        repeat (10) @(posedge pclk);
        chk({u_partner.asked, provider_role}, 3'b100);
        sw(2'b10, 1'b1);
        $display("dual role done");
    endtask : t_dual
    task automatic t_micro;
        logic [32:0] r;
        setup(4'h2, 4'h5, 1'b1, 1'b0);
        sw(2'b01, 1'b0);
        pins.micro_a_present <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h3, r);
        repeat (8) @(posedge pclk);
        chk({u_partner.asked, provider_role}, 2'b01);
        sw(2'b01, 1'b1);
        $display("micro done");
    endtask : t_micro

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        repeat (20000) @(posedge pclk);
        err_count++;
        $display("BAD %0t watchdog expired", $time);
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pins = '0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_pdo();
        t_dfp();
        t_ufp();
        t_dual();
        t_micro();
        end_of_test();
    end
endmodule : tb
